// ### rtl/ieq_pkg.sv
package ieq_pkg;

  // ----------------------------------------------------------------
  // Queue geometry
  // ----------------------------------------------------------------
  localparam int unsigned DEPTH      = 20;
  localparam int unsigned PTR_W      = 5;
  localparam int unsigned CODE_W     = 16;
  localparam int unsigned MSG_ID_W   = 8;
  localparam int unsigned MSG_MAX_CH = 80;

  localparam logic [PTR_W-1:0] PTR_LAST  = 5'h13;
  localparam logic [PTR_W-1:0] PTR_ZERO  = 5'h00;
  localparam logic [PTR_W:0]   CNT_FULL  = 6'h14;
  localparam logic [PTR_W:0]   CNT_RESET = 6'h00;

  // ----------------------------------------------------------------
  // Fixed codes and message identifiers
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0]   CODE_OVERFLOW = 16'hfea2;  // -350
  localparam logic [CODE_W-1:0]   CODE_NONE     = 16'h0000;  // +0
  localparam logic [MSG_ID_W-1:0] MSG_TOO_MANY  = 8'hfe;
  localparam logic [MSG_ID_W-1:0] MSG_NO_ERROR  = 8'hff;     // Remote wording
  localparam logic [MSG_ID_W-1:0] MSG_NO_ERRORS = 8'hfd;     // Panel wording

  // ----------------------------------------------------------------
  // Self-test timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ       = 10_000_000;
  localparam longint unsigned TEST_TIME_MS = 2000;
  localparam longint unsigned TEST_CYCLES  = TEST_TIME_MS * CLK_HZ / 1000;

  // One queue record: signed code plus a message index into text ROM
  typedef struct packed {
    logic [CODE_W-1:0]   code;
    logic [MSG_ID_W-1:0] msg;
  } ieq_entry_t;

  typedef enum logic {
    IEQ_SRC_REMOTE,
    IEQ_SRC_PANEL
  } ieq_src_t;

endpackage

// ### rtl/ieq_selftest.sv
`timescale 1ns/1ps
module ieq_selftest #(
  parameter longint unsigned TEST_CYCLES = ieq_pkg::TEST_CYCLES
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // Control
  input  wire logic start,
  input  wire logic unit_fail,
  // Result
  output logic      busy,
  output logic      done,
  output logic      fail
);

  typedef enum logic [1:0] {
    IEQ_ST_IDLE,
    IEQ_ST_RUN,
    IEQ_ST_DONE
  } ieq_st_t;

  ieq_st_t      state;
  logic [31:0]  count;
  logic         seen_fail;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state     <= IEQ_ST_IDLE;
      count     <= 32'h0;
      seen_fail <= 1'b0;
    end else begin
      unique case (state)
        IEQ_ST_IDLE: begin
          if (start) begin
            state     <= IEQ_ST_RUN;
            count     <= 32'h0;
            seen_fail <= 1'b0;
          end
        end
        IEQ_ST_RUN: begin
          seen_fail <= seen_fail | unit_fail;
          // Fixed run length; about 2 s at 10 MHz
          if (count == 32'(TEST_CYCLES - 1)) begin // R14
            state <= IEQ_ST_DONE;
          end else begin
            count <= count + 32'h1;
          end
        end
        IEQ_ST_DONE: begin
          state <= IEQ_ST_IDLE;
        end
        default: state <= IEQ_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Done pulse and fail result; fail held until next start
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fail <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= (state == IEQ_ST_RUN) && (count == 32'(TEST_CYCLES - 1));
      if (start && state == IEQ_ST_IDLE) begin
        fail <= 1'b0;
      end else if (state == IEQ_ST_RUN && count == 32'(TEST_CYCLES - 1)) begin
        fail <= seen_fail | unit_fail; // R15
      end
    end
  end

  assign busy = (state != IEQ_ST_IDLE);

endmodule // ieq_selftest

// ### rtl/ieq_error_queue.sv
`timescale 1ns/1ps
// Function
// R1: Queue holds up to 20 code/message records
// R2: Reads return the oldest entry first
// R3: Indicator lit while any entry queued
// R4: Indicator off once queue drained
// R5: One beep pulse per new fault
// R6: Full queue: newest becomes -350 overflow
// R7: After overflow, drop faults until read
// R8: Empty read gives +0 no-error message
// R9: Power-up and clear-status empty queue
// R10: Reset command leaves queue untouched
// R11: Message text at most 80 characters
// R12: Panel key pops and shows one entry
// R13: Failed power-on self-test lights indicator
// R14: Complete self-test ~2 s, then pass/fail
// R15: Test query answers 0 pass, 1 fail
// R16: Operator holds key 5 s at power-on
// R17: Same-cycle fault and read: pop then push
// R18: Any removal ends overflow blocking
module ieq_error_queue #(
  parameter longint unsigned TEST_CYCLES = ieq_pkg::TEST_CYCLES
) (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rstn,
  // Fault sources
  input  wire logic               fault_valid,
  input  wire ieq_pkg::ieq_entry_t fault_entry,
  // Readers
  input  wire logic               remote_read,
  input  wire logic               panel_read,
  // Status commands
  input  wire logic               clear_status,
  input  wire logic               reset_cmd,
  // Self-test
  input  wire logic               post_done,
  input  wire logic               post_fail,
  input  wire logic               test_start,
  input  wire logic               test_unit_fail,
  output logic                    test_busy,
  output logic                    test_done,
  output logic                    test_result,
  // Read answer
  output logic                    rd_valid,
  output ieq_pkg::ieq_src_t       rd_src,
  output ieq_pkg::ieq_entry_t     rd_entry,
  // Indicators
  output logic                    err_led,
  output logic                    beep,
  output logic [5:0]              count
);

  ieq_pkg::ieq_entry_t mem [ieq_pkg::DEPTH];
  logic [ieq_pkg::PTR_W-1:0] rd_ptr;
  logic [ieq_pkg::PTR_W-1:0] wr_ptr;
  logic                      blocked;
  logic                      post_bad;
  logic                      test_bad;
  logic                      st_done;
  logic                      st_fail;
  logic                      do_read;
  logic                      do_pop;
  logic                      full_now;
  logic                      do_push;
  logic                      do_ovf;
  logic [ieq_pkg::PTR_W-1:0] newest;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [ieq_pkg::PTR_W-1:0] wrap_inc(
    input logic [ieq_pkg::PTR_W-1:0] p
  );
    wrap_inc = (p == ieq_pkg::PTR_LAST) ? ieq_pkg::PTR_ZERO : p + 5'h01;
  endfunction

  function automatic logic [ieq_pkg::PTR_W-1:0] wrap_dec(
    input logic [ieq_pkg::PTR_W-1:0] p
  );
    wrap_dec = (p == ieq_pkg::PTR_ZERO) ? ieq_pkg::PTR_LAST : p - 5'h01;
  endfunction

  // ----------------------------------------------------------------
  // Queue control
  // ----------------------------------------------------------------
  // Remote read wins over a panel press in the same cycle
  assign do_read  = remote_read | panel_read;
  assign do_pop   = do_read && (count != ieq_pkg::CNT_RESET);
  // Pop is applied first so a freed slot is seen by the push
  assign full_now = (count == ieq_pkg::CNT_FULL) && !do_pop;              // R17
  assign do_push  = fault_valid && !full_now && !(blocked && !do_pop);   // R7 R18
  assign do_ovf   = fault_valid && full_now && !blocked;                 // R6
  assign newest   = wrap_dec(wr_ptr);

  // Text is only an index; ROM strings elsewhere keep to 80 characters
  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= fault_entry;                                       // R1 R11
    end else if (do_ovf) begin
      mem[newest] <= '{code: ieq_pkg::CODE_OVERFLOW, msg: ieq_pkg::MSG_TOO_MANY}; // R6
    end
  end

  // Reset command deliberately not wired here
  always_ff @(posedge ref_clk or negedge rstn) begin                    // R10
    if (!rstn) begin
      rd_ptr <= ieq_pkg::PTR_ZERO;                                      // R9
      wr_ptr <= ieq_pkg::PTR_ZERO;
      count  <= ieq_pkg::CNT_RESET;
    end else if (clear_status) begin
      rd_ptr <= ieq_pkg::PTR_ZERO;                                      // R9
      wr_ptr <= ieq_pkg::PTR_ZERO;
      count  <= ieq_pkg::CNT_RESET;
    end else begin
      if (do_pop) begin
        rd_ptr <= wrap_inc(rd_ptr);                                     // R2 R12
      end
      if (do_push) begin
        wr_ptr <= wrap_inc(wr_ptr);
      end
      count <= count + {5'h00, do_push} - {5'h00, do_pop};              // R17
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      blocked <= 1'b0;
    end else if (clear_status || do_pop) begin
      blocked <= 1'b0;                                                  // R18
    end else if (do_ovf) begin
      blocked <= 1'b1;                                                  // R7
    end
  end

  // ----------------------------------------------------------------
  // Read answer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_valid <= 1'b0;
      rd_src   <= ieq_pkg::IEQ_SRC_REMOTE;
      rd_entry <= '0;
    end else begin
      rd_valid <= do_read && !clear_status;
      if (do_read) begin
        rd_src <= remote_read ? ieq_pkg::IEQ_SRC_REMOTE : ieq_pkg::IEQ_SRC_PANEL;
        if (count != ieq_pkg::CNT_RESET) begin
          rd_entry <= mem[rd_ptr];                                      // R2
        end else begin
          rd_entry <= '{code: ieq_pkg::CODE_NONE,                       // R8
                        msg:  remote_read ? ieq_pkg::MSG_NO_ERROR : ieq_pkg::MSG_NO_ERRORS};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Beep and indicator
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      beep <= 1'b0;
    end else begin
      // Beeps even when the fault is dropped: it was still generated
      beep <= fault_valid;                                              // R5
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      post_bad <= 1'b0;
      test_bad <= 1'b0;
    end else begin
      if (post_done) begin
        post_bad <= post_fail;                                          // R13
      end
      if (st_done) begin
        test_bad <= st_fail;                                            // R14
      end
    end
  end

  // Operator holding the key 5 s is decoded upstream into test_start
  ieq_selftest #(
    .TEST_CYCLES (TEST_CYCLES)
  ) u_selftest (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .start     (test_start),                                            // R16
    .unit_fail (test_unit_fail),
    .busy      (test_busy),
    .done      (st_done),
    .fail      (st_fail)
  );

  assign test_done   = st_done;
  assign test_result = st_fail;                                         // R15
  assign err_led     = (count != ieq_pkg::CNT_RESET) | post_bad | test_bad; // R3 R4 R13

endmodule // ieq_error_queue

// ### testbench/ieq_error_queue_checker.sv
`timescale 1ns/1ps
module ieq_error_queue_checker (
  // Clock and reset
  input wire logic                ref_clk,
  input wire logic                rstn,
  // Requests
  input wire logic                fault_valid,
  input wire logic                remote_read,
  input wire logic                panel_read,
  input wire logic                clear_status,
  input wire logic                reset_cmd,
  // Answers
  input wire logic                rd_valid,
  input wire ieq_pkg::ieq_src_t   rd_src,
  input wire ieq_pkg::ieq_entry_t rd_entry,
  input wire logic                err_led,
  input wire logic                beep,
  input wire logic [5:0]          count
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic rd;
  assign rd = remote_read | panel_read;

  beep_once_a: assert property (beep == $past(fault_valid))
    else $error("beep not one pulse per fault");
  led_busy_a: assert property (count != 6'h00 |-> err_led)
    else $error("indicator dark with entries held");
  count_cap_a: assert property (count <= 6'h14)
    else $error("occupancy above capacity");
  count_step_a: assert property (fault_valid && !rd && !clear_status && count < 6'h14
    |=> count == $past(count) + 6'h01) else $error("fault not stored");
  read_ans_a: assert property (rd && !clear_status |=> rd_valid)
    else $error("read without answer");
  panel_src_a: assert property (panel_read && !remote_read && !clear_status
    |=> rd_src == ieq_pkg::IEQ_SRC_PANEL) else $error("panel answer wrong source");
  empty_read_a: assert property (remote_read && count == 6'h00 && !fault_valid
    && !clear_status |=> rd_entry == {16'h0000, 8'hff}) else $error("empty read wrong");
  clear_all_a: assert property (clear_status && !fault_valid |=> count == 6'h00)
    else $error("clear left entries");
  keep_full_a: assert property (fault_valid && count == 6'h14 && !clear_status
    |=> count == 6'h14) else $error("full queue count moved");
  rst_cmd_a: assert property (reset_cmd && !fault_valid && !rd && !clear_status
    |=> $stable(count)) else $error("reset command changed queue");
endmodule // ieq_error_queue_checker

bind ieq_error_queue ieq_error_queue_checker chk (.ref_clk, .rstn, .fault_valid,
  .remote_read, .panel_read, .clear_status, .reset_cmd, .rd_valid, .rd_src,
  .rd_entry, .err_led, .beep, .count);

// ### testbench/ieq_reader.sv
`timescale 1ns/1ps
module ieq_reader (
  // Clock
  input  wire logic                ref_clk,
  // Read strobes
  output logic                     remote_read,
  output logic                     panel_read,
  // Answer
  input  wire logic                rd_valid,
  input  wire ieq_pkg::ieq_entry_t rd_entry
);
  initial begin
    remote_read = 1'b0;
    panel_read  = 1'b0;
  end
  // Host or key: waits gap cycles, so slow readers are modelled too
  task automatic pop(input logic panel, input int gap, output logic ok,
                     output ieq_pkg::ieq_entry_t e);
    repeat (gap) begin
      @(posedge ref_clk);
      #1;
    end
    remote_read = ~panel;
    panel_read  = panel;
    @(posedge ref_clk);
    #1;
    remote_read = 1'b0;
    panel_read  = 1'b0;
    ok = rd_valid;
    e  = rd_entry;
  endtask
endmodule // ieq_reader

// ### testbench/ieq_error_queue_tb.sv
`timescale 1ns/1ps
module ieq_error_queue_tb;
  logic                ref_clk = 1'b0;
  logic                rstn = 1'b0;
  logic                fault_valid = 1'b0;
  ieq_pkg::ieq_entry_t fault_entry = '0;
  logic                clear_status = 1'b0, reset_cmd = 1'b0, post_done = 1'b0;
  logic                post_fail = 1'b0, test_start = 1'b0, test_unit_fail = 1'b0;
  logic                remote_read, panel_read, test_busy, test_done, test_result;
  logic                rd_valid, err_led, beep, ok;
  ieq_pkg::ieq_src_t   rd_src;
  ieq_pkg::ieq_entry_t rd_entry, e;
  logic [5:0]          count;
  int                  mismatches = 0;
  int                  total_checks = 0;

  always #50 ref_clk = ~ref_clk;

  // Short self-test count keeps the run brief
  ieq_error_queue #(.TEST_CYCLES(10)) dut (.ref_clk, .rstn, .fault_valid, .fault_entry,
    .remote_read, .panel_read, .clear_status, .reset_cmd, .post_done, .post_fail,
    .test_start, .test_unit_fail, .test_busy, .test_done, .test_result, .rd_valid,
    .rd_src, .rd_entry, .err_led, .beep, .count);
  ieq_reader rdr (.ref_clk, .remote_read, .panel_read, .rd_valid, .rd_entry);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cmp(input string name, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic conclude;
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick;
    s = 1'b0;
  endtask
  // Idle cycle after each fault so the strobe never toggles twice at once
  task automatic push(input logic [15:0] code);
    fault_entry = {code, 8'h01};
    pulse(fault_valid);
    cmp("beep", 24'h1, 24'(beep));
    tick;
  endtask
  task automatic pop_chk(input logic panel, input int gap, input logic [23:0] exp);
    rdr.pop(panel, gap, ok, e);
    cmp("rd_valid", 24'h1, 24'(ok));
    cmp("rd_entry", exp, e);
  endtask
  task automatic run_test(input logic bad);
    test_unit_fail = bad;
    pulse(test_start);
    cmp("test_busy", 24'h1, 24'(test_busy));
    for (int i = 0; i < 40 && test_done !== 1'b1; i++) tick;
    if (test_done !== 1'b1) begin
      mismatches++;
      conclude;
    end
    cmp("test_result", 24'(bad), 24'(test_result));
    // Indicator takes the result one cycle after the done pulse
    tick;
    cmp("err_led", 24'(bad), 24'(err_led));
    cmp("test_busy", 24'h0, 24'(test_busy));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_fifo;
    for (int i = 1; i <= 3; i++) push(16'hff80 + 16'(i));
    cmp("count", 24'h3, 24'(count));
    cmp("err_led", 24'h1, 24'(err_led));
    for (int i = 1; i <= 3; i++) pop_chk(1'b0, i, {16'hff80 + 16'(i), 8'h01});
    cmp("err_led", 24'h0, 24'(err_led));
  endtask
  task automatic sc_empty;
    pop_chk(1'b0, 1, {16'h0000, 8'hff});
    pop_chk(1'b1, 1, {16'h0000, 8'hfd});
    cmp("rd_src", 24'h1, 24'(rd_src));
  endtask
  task automatic sc_overflow;
    for (int i = 1; i <= 21; i++) push(16'(i));
    cmp("count", 24'h14, 24'(count));
    push(16'h0055);
    pulse(reset_cmd);
    cmp("count", 24'h14, 24'(count));
    fork
      push(16'h0063);
      pop_chk(1'b0, 0, {16'h0001, 8'h01});
    join
    cmp("count", 24'h14, 24'(count));
    for (int i = 2; i <= 19; i++) pop_chk(1'b0, 1, {16'(i), 8'h01});
    pop_chk(1'b0, 1, {16'hfea2, 8'hfe});
    pop_chk(1'b1, 1, {16'h0063, 8'h01});
    cmp("count", 24'h0, 24'(count));
  endtask
  task automatic sc_clear;
    push(16'h0007);
    push(16'h0008);
    pulse(clear_status);
    cmp("count", 24'h0, 24'(count));
    cmp("err_led", 24'h0, 24'(err_led));
  endtask
  task automatic sc_selftest;
    run_test(1'b1);
    run_test(1'b0);
    post_fail = 1'b1;
    pulse(post_done);
    cmp("err_led", 24'h1, 24'(err_led));
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    tick;
    cmp("count", 24'h0, 24'(count));
    sc_fifo;
    sc_empty;
    sc_overflow;
    sc_clear;
    sc_selftest;
    conclude;
  end
endmodule // ieq_error_queue_tb
